// File: hw/mrbc_pkg.sv
// Package with constants and types for the register bus core
package mrbc_pkg;
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          BASIC_CYCLE_NS   = 260;
	localparam int          CYCLE_CLKS_MIN   = (BASIC_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          JUMP_CYCLE_NS    = 520;
	localparam int          JUMP_CLKS        = (JUMP_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  STRETCH_RESET    = 8'h00;
	localparam logic [4:0]  PH_B_START       = 5'h14;
	localparam logic [4:0]  PH_B_END         = 5'h16;
	localparam logic [4:0]  PH_D_START       = 5'h13;
	localparam logic [4:0]  PH_D_END         = 5'h17;
	localparam int          PC_WIDTH         = 12;
	localparam int          PC_UPPER_W       = 4;
	localparam int          PC_LOWER_W       = 8;
	localparam int          LITERAL_W        = 8;
	localparam logic [3:0]  SEL_WORK         = 4'h0;
	localparam logic [3:0]  SEL_COND         = 4'h1;
	localparam logic [3:0]  SEL_DISC_FIRST   = 4'h2;
	localparam logic [3:0]  SEL_DISC_SECOND  = 4'h3;
	localparam logic [3:0]  SEL_PC_UPPER     = 4'h4;
	localparam logic [3:0]  SEL_PC_LOWER     = 4'h5;
	localparam logic [3:0]  SEL_EXT_FIRST    = 4'h6;
	localparam int          CF_CARRY_LINK    = 0;
	localparam int          CF_SIGN          = 1;
	localparam int          CF_POSITIVE      = 2;
	localparam int          CF_ZERO          = 3;
	localparam int          CF_OVERFLOW      = 4;
	localparam int          CF_PARITY_ERROR  = 5;
	localparam int          CF_OUTSIDE_ONE   = 6;
	localparam int          CF_OUTSIDE_TWO   = 7;
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [11:0] PC_RESET         = 12'h000;
	localparam logic [15:0] INSTR_RESET      = 16'h0000;

	// Datapath request for one micro-instruction
	typedef struct packed {
		logic [15:0] instr;
		logic [3:0]  dest_sel;
		logic        dest_en;
		logic [7:0]  result;
		logic        arith;
		logic        logical;
		logic        carry_out;
		logic        operand_sign;
		logic        overflow;
		logic        parity_test;
		logic        cond_write;
	} mrbc_op_t;

	// Link to auxiliary assemblies
	typedef struct packed {
		logic [3:0] sel;
		logic [7:0] result;
		logic       sink;
		logic       phase_d;
		logic       phase_b;
	} mrbc_aux_t;
endpackage

// File: hw/mrbc_core.sv
// Register core: instruction holder, program counter, internal registers, auxiliary bus
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Ordinary micro-instruction completes in one 260 ns basic cycle.
// - Counter is 12 bits, 4 upper plus 8 lower, addressing 4096 words.
// - Instruction holder keeps the word; low bits give the literal.
// - Counter advances by one before every fetch, except after a counter load.
// - Counter upper as destination loads from result and work register, lower from result alone; takes two cycles.
// - Select codes 0 to 5 internal registers, 6 to 15 external.
// - Work register read and write; gives low jump address bits.
// - Bit 0 takes adder carry-out and keeps it for later bytes.
// - Bit 1 records sign of one operand of last arithmetic.
// - Bit 2 set on positive result, bit 3 on all-zero result.
// - Bit 4 set when arithmetic may have overflowed.
// - Bit 5 set when read bus parity looks wrong.
// - Bits 6 and 7 follow two outside condition inputs.
// - Both discrete registers always shown on two output buses.
// - Counter parts are write-only destinations.
// - Codes 6 to 15 are registers in attached assemblies.
// - Result bus carries data for an external destination.
// - Read bus has a parity line; checked only on program request.
// - Write qualifier high for whole instruction with a destination.
// - Write strobe pulses once per instruction, in its first basic cycle; destination captures on it.
// - Earlier phase pulse lies inside the write strobe.
// - Basic cycle at least 260 ns and can be lengthened.
module mrbc_core
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic [7:0]        cycle_stretch,
	input  wire mrbc_pkg::mrbc_op_t op_in,
	input  wire logic              op_valid,
	input  wire logic [15:0]       fetch_word,
	input  wire logic [7:0]        read_bus,
	input  wire logic              read_parity,
	input  wire logic              outside_condition_one,
	input  wire logic              outside_condition_two,
	output mrbc_pkg::mrbc_aux_t    aux_out,
	output logic [7:0]             discrete_first_bus,
	output logic [7:0]             discrete_second_bus,
	output logic [11:0]            program_address,
	output logic                   fetch_strobe,
	output logic                   op_ready,
	output logic [15:0]            instr_hold,
	output logic [7:0]             literal_out,
	output logic [7:0]             work_out,
	output logic [7:0]             cond_out,
	output logic [7:0]             read_data
);
	typedef enum logic [1:0] {MRBC_IDLE, MRBC_EXEC, MRBC_JUMP} mrbc_state_t;

	mrbc_state_t       state_ff;
	mrbc_state_t       nxt_state;
	logic [9:0]        phase_ff;
	logic [9:0]        nxt_phase;
	mrbc_pkg::mrbc_op_t op_ff;
	logic [15:0]       instr_ff;
	logic [11:0]       pc_ff;
	logic [11:0]       nxt_pc;
	logic [7:0]        work_ff;
	logic [7:0]        cond_ff;
	logic [7:0]        nxt_cond;
	logic [7:0]        disc_first_ff;
	logic [7:0]        disc_second_ff;
	logic [7:0]        stretch_ff;
	logic [3:0]        sel_ff;
	logic [7:0]        result_ff;
	logic              sink_ff;
	logic              phase_d_ff;
	logic              phase_b_ff;
	logic              fetch_ff;
	logic              ready_ff;
	logic [7:0]        read_ff;

	wire [9:0] basic_len;
	wire [9:0] cycle_end;
	wire       last_tick;
	wire       strobe_win;
	wire       early_win;
	wire       ext_sel;
	wire       dest_pc;
	wire       write_now;
	wire       bus_parity_bad;
	wire [7:0] sel_read;
	wire       op_dest_pc;
	wire [9:0] rel_phase;
	wire       take;
	wire       update_now;

	// Basic cycle length, lengthened by software stretch
	assign basic_len  = 10'(mrbc_pkg::CYCLE_CLKS_MIN) + {2'h0, stretch_ff};
	assign cycle_end  = (state_ff == MRBC_JUMP) ? {basic_len[8:0], 1'b0} - 10'h1
		: basic_len - 10'h1;
	assign last_tick  = (state_ff != MRBC_IDLE) && (phase_ff == cycle_end);
	assign rel_phase  = phase_ff + 10'(mrbc_pkg::CYCLE_CLKS_MIN) - basic_len;
	assign strobe_win = (rel_phase >= 10'(mrbc_pkg::PH_D_START))
		&& (rel_phase <= 10'(mrbc_pkg::PH_D_END))
		&& (phase_ff < basic_len);
	assign early_win  = (rel_phase >= 10'(mrbc_pkg::PH_B_START))
		&& (rel_phase <= 10'(mrbc_pkg::PH_B_END))
		&& (phase_ff < basic_len);
	// Update point for registers and flags, with or without a destination
	assign update_now = (state_ff != MRBC_IDLE)
		&& (rel_phase == 10'(mrbc_pkg::PH_D_END)) && (phase_ff < basic_len);
	assign write_now  = update_now && op_ff.dest_en;
	assign take       = (state_ff == MRBC_IDLE) && op_valid;
	assign ext_sel    = (op_ff.dest_sel >= mrbc_pkg::SEL_EXT_FIRST);
	assign dest_pc    = op_ff.dest_en && ((op_ff.dest_sel == mrbc_pkg::SEL_PC_UPPER)
		|| (op_ff.dest_sel == mrbc_pkg::SEL_PC_LOWER));
	assign op_dest_pc = op_in.dest_en && ((op_in.dest_sel == mrbc_pkg::SEL_PC_UPPER)
		|| (op_in.dest_sel == mrbc_pkg::SEL_PC_LOWER));
	assign bus_parity_bad = ~^{read_bus, read_parity};

	// Internal readback by select code; counter parts read as zero
	assign sel_read = (op_ff.dest_sel == mrbc_pkg::SEL_WORK)        ? work_ff
		: (op_ff.dest_sel == mrbc_pkg::SEL_COND)        ? cond_ff
		: (op_ff.dest_sel == mrbc_pkg::SEL_DISC_FIRST)  ? disc_first_ff
		: (op_ff.dest_sel == mrbc_pkg::SEL_DISC_SECOND) ? disc_second_ff
		: ext_sel ? read_bus : 8'h00;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		case (state_ff)
			MRBC_IDLE:
			begin
				nxt_phase = 10'h0;
				if (op_valid)
				begin
					nxt_state = op_dest_pc ? MRBC_JUMP : MRBC_EXEC;
				end
			end
			MRBC_EXEC, MRBC_JUMP:
			begin
				nxt_phase = phase_ff + 10'h1;
				if (last_tick)
				begin
					nxt_state = MRBC_IDLE;
					nxt_phase = 10'h0;
				end
			end
			default:
			begin
				nxt_state = MRBC_IDLE;
				nxt_phase = 10'h0;
			end
		endcase
	end

	always_comb
	begin
		nxt_pc = pc_ff;
		// Jump load replaces the increment, both at the fetch point
		if (last_tick)
		begin
			if (dest_pc && (op_ff.dest_sel == mrbc_pkg::SEL_PC_UPPER))
			begin
				nxt_pc = {op_ff.result[mrbc_pkg::PC_UPPER_W-1:0], work_ff};
			end
			else if (dest_pc)
			begin
				nxt_pc = {pc_ff[11:8], op_ff.result};
			end
			else
			begin
				nxt_pc = pc_ff + 12'h1;
			end
		end
	end

	always_comb
	begin
		nxt_cond = cond_ff;
		if (write_now && (op_ff.dest_sel == mrbc_pkg::SEL_COND))
		begin
			nxt_cond = op_ff.result;
		end
		if (update_now && op_ff.cond_write)
		begin
			if (op_ff.arith)
			begin
				nxt_cond[mrbc_pkg::CF_CARRY_LINK] = op_ff.carry_out;
				nxt_cond[mrbc_pkg::CF_SIGN]       = op_ff.operand_sign;
				nxt_cond[mrbc_pkg::CF_OVERFLOW]   = op_ff.overflow;
			end
			if (op_ff.arith || op_ff.logical)
			begin
				nxt_cond[mrbc_pkg::CF_POSITIVE] = ~op_ff.result[7]
					&& (op_ff.result != 8'h00);
			end
			nxt_cond[mrbc_pkg::CF_ZERO] = (op_ff.result == 8'h00);
		end
		if (update_now && op_ff.parity_test)
		begin
			nxt_cond[mrbc_pkg::CF_PARITY_ERROR] = bus_parity_bad;
		end
		nxt_cond[mrbc_pkg::CF_OUTSIDE_ONE] = outside_condition_one;
		nxt_cond[mrbc_pkg::CF_OUTSIDE_TWO] = outside_condition_two;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_ff   <= MRBC_IDLE;
			phase_ff   <= 10'h0;
			pc_ff      <= mrbc_pkg::PC_RESET;
			cond_ff    <= mrbc_pkg::REG_RESET;
			stretch_ff <= mrbc_pkg::STRETCH_RESET;
		end
		else
		begin
			state_ff   <= nxt_state;
			phase_ff   <= nxt_phase;
			pc_ff      <= nxt_pc;
			cond_ff    <= nxt_cond;
			stretch_ff <= (state_ff == MRBC_IDLE) ? cycle_stretch : stretch_ff;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			op_ff    <= '0;
			instr_ff <= mrbc_pkg::INSTR_RESET;
		end
		else if ((state_ff == MRBC_IDLE) && op_valid)
		begin
			op_ff    <= op_in;
			instr_ff <= op_in.instr;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			work_ff <= mrbc_pkg::REG_RESET;
		end
		else if (write_now && (op_ff.dest_sel == mrbc_pkg::SEL_WORK))
		begin
			work_ff <= op_ff.result;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			disc_first_ff <= mrbc_pkg::REG_RESET;
		end
		else if (write_now && (op_ff.dest_sel == mrbc_pkg::SEL_DISC_FIRST))
		begin
			disc_first_ff <= op_ff.result;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			disc_second_ff <= mrbc_pkg::REG_RESET;
		end
		else if (write_now && (op_ff.dest_sel == mrbc_pkg::SEL_DISC_SECOND))
		begin
			disc_second_ff <= op_ff.result;
		end
	end

	// Select code stands from the first cycle of an operation
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sel_ff <= 4'h0;
		end
		else
		begin
			sel_ff <= take ? op_in.dest_sel : op_ff.dest_sel;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			result_ff <= mrbc_pkg::REG_RESET;
		end
		else
		begin
			result_ff <= take ? op_in.result : op_ff.result;
		end
	end

	// Qualifier held over the whole operation, through its last cycle
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			sink_ff <= 1'b0;
		end
		else
		begin
			sink_ff <= take ? op_in.dest_en
				: ((state_ff != MRBC_IDLE) && op_ff.dest_en);
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			phase_d_ff <= 1'b0;
		end
		else
		begin
			phase_d_ff <= (state_ff != MRBC_IDLE) && strobe_win;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			phase_b_ff <= 1'b0;
		end
		else
		begin
			phase_b_ff <= (state_ff != MRBC_IDLE) && early_win;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			fetch_ff <= 1'b0;
		end
		else
		begin
			fetch_ff <= last_tick;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ready_ff <= 1'b0;
		end
		else
		begin
			ready_ff <= (nxt_state == MRBC_IDLE);
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			read_ff <= mrbc_pkg::REG_RESET;
		end
		else
		begin
			read_ff <= sel_read;
		end
	end

	assign aux_out             = mrbc_pkg::mrbc_aux_t'({sel_ff, result_ff, sink_ff,
		phase_d_ff, phase_b_ff});
	assign discrete_first_bus  = disc_first_ff;
	assign discrete_second_bus = disc_second_ff;
	assign program_address     = pc_ff;
	assign fetch_strobe        = fetch_ff;
	assign op_ready            = ready_ff;
	assign instr_hold          = instr_ff;
	assign literal_out         = instr_ff[mrbc_pkg::LITERAL_W-1:0];
	assign work_out            = work_ff;
	assign cond_out            = cond_ff;
	assign read_data           = read_ff;
endmodule // mrbc_core

`default_nettype wire

// File: tb/mrbc_core_asserts.sv
// Port assertions for the register bus core
`timescale 1ns/1ns
`default_nettype none
module mrbc_core_asserts
(
	input wire logic                clock,
	input wire logic                sys_rst,
	input wire logic [7:0]          cycle_stretch,
	input wire logic                op_valid,
	input wire logic                outside_condition_one,
	input wire mrbc_pkg::mrbc_aux_t aux_out,
	input wire logic [7:0]          discrete_first_bus,
	input wire logic [11:0]         program_address,
	input wire logic                fetch_strobe,
	input wire logic                op_ready,
	input wire logic [15:0]         instr_hold,
	input wire logic [7:0]          literal_out,
	input wire logic [7:0]          cond_out
);
	logic [8:0] low_ff;
	logic [7:0] st_ff;
	wire  logic jump = aux_out.sink && aux_out.sel[3:1] == 3'h2;
	always_ff @(posedge clock)
	begin
		low_ff <= (sys_rst || op_ready) ? 9'h000 : low_ff + 9'h001;
		st_ff <= (op_valid && op_ready) ? cycle_stretch : st_ff;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence d_pulse;
		aux_out.phase_d [*5] ##1 !aux_out.phase_d;
	endsequence
	ready_fall_a: assert property (op_valid && op_ready |=> !op_ready)
		else $error("op not taken");
	strobe_len_a: assert property ($rose(aux_out.phase_d) |-> d_pulse)
		else $error("strobe length");
	early_in_a: assert property (aux_out.phase_b |-> aux_out.phase_d)
		else $error("early pulse outside strobe");
	cond_ext_a: assert property (!$past(sys_rst) |-> cond_out[6] == $past(outside_condition_one))
		else $error("outside condition");
	disc_bus_a: assert property (!$past(sys_rst) && $changed(discrete_first_bus) |->
		$past(aux_out.sink) && $past(aux_out.sel) == mrbc_pkg::SEL_DISC_FIRST)
		else $error("discrete bus change");
	bus_hold_a: assert property (!op_ready && !$past(op_ready) |->
		$stable({aux_out.sel, aux_out.result, aux_out.sink}))
		else $error("bus not held");
	pc_step_a: assert property (!$past(sys_rst) && $changed(program_address) |-> fetch_strobe)
		else $error("counter moved off fetch");
	op_len_a: assert property ($rose(op_ready) && low_ff > 9'h001 |->
		low_ff == (jump ? 9'h034 + {st_ff, 1'b0} : 9'h01a + {1'b0, st_ff}))
		else $error("op length");
	lit_a: assert property (literal_out == instr_hold[7:0])
		else $error("literal");
endmodule // mrbc_core_asserts
bind mrbc_core mrbc_core_asserts chk (.clock, .sys_rst, .cycle_stretch, .op_valid,
	.outside_condition_one, .aux_out, .discrete_first_bus, .program_address, .fetch_strobe,
	.op_ready, .instr_hold, .literal_out, .cond_out);
`default_nettype wire

// File: tb/mrbc_aux_model.sv
// Auxiliary assembly model holding the external registers
`timescale 1ns/1ns
`default_nettype none
module mrbc_aux_model
(
	input wire logic                clock,
	input wire mrbc_pkg::mrbc_aux_t aux,
	input wire logic                bad_par,
	output logic [7:0]              read_bus,
	output logic                    read_parity
);
	logic [7:0] ext_ff [16] = '{default: 8'h00};
	logic [7:0] junk_ff = 8'h5a;
	logic       pd_ff = 1'b0;
	wire  logic hit = aux.sel >= mrbc_pkg::SEL_EXT_FIRST;
	// Unselected bus shows a toggling pattern
	assign read_bus = hit ? ext_ff[aux.sel] : junk_ff;
	assign read_parity = ~^read_bus ^ bad_par;
	always_ff @(posedge clock)
	begin
		junk_ff <= ~junk_ff;
		pd_ff <= aux.phase_d;
		if (hit && aux.sink && aux.phase_d && !pd_ff)
			ext_ff[aux.sel] <= aux.result;
	end
endmodule // mrbc_aux_model
`default_nettype wire

// File: tb/mrbc_core_tb.sv
// Self-checking bench for the register bus core
`timescale 1ns/1ns
`default_nettype none
module mrbc_core_tb;
	logic                clock = 1'b0;
	logic                sys_rst = 1'b1;
	logic [7:0]          cycle_stretch = 8'h00;
	mrbc_pkg::mrbc_op_t  op_in = '0;
	logic                op_valid = 1'b0;
	logic                bad_par = 1'b0;
	logic                oc1 = 1'b0;
	logic                oc2 = 1'b0;
	mrbc_pkg::mrbc_aux_t aux_out;
	logic [7:0]          rbus, disc1, disc2, lit, work, cond, rdata;
	logic [15:0]         ihold;
	logic [11:0]         pc, epc = 12'h000;
	logic                rpar, fstb, op_ready, exp_par = 1'b0;
	logic [4:0]          ecf = 5'h00;
	int                  ereg [16] = '{default: 0};
	int                  error_cnt = 0, compares = 0, cyc = 0;
	mrbc_core uut
	(
		.clock, .sys_rst, .cycle_stretch, .op_in, .op_valid, .fetch_word(16'h0000),
		.read_bus(rbus), .read_parity(rpar), .outside_condition_one(oc1),
		.outside_condition_two(oc2), .aux_out, .discrete_first_bus(disc1),
		.discrete_second_bus(disc2), .program_address(pc), .fetch_strobe(fstb), .op_ready,
		.instr_hold(ihold), .literal_out(lit), .work_out(work), .cond_out(cond),
		.read_data(rdata)
	);
	mrbc_aux_model far (.clock, .aux(aux_out), .bad_par, .read_bus(rbus), .read_parity(rpar));
	initial forever #5 clock = ~clock;
	task automatic finish_test;
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_ready;
		int n = 0;
		while (op_ready !== 1'b1 && n++ < 300)
			@(posedge clock) #1;
	endtask
	task automatic run_op(input logic [3:0] s, input logic d, input logic [7:0] r,
		input logic a, input logic pt);
		wait_ready();
		op_in = '0;
		op_in.instr = 16'($urandom);
		{op_in.dest_sel, op_in.dest_en, op_in.result} = {s, d, r};
		{op_in.arith, op_in.cond_write, op_in.parity_test} = {a, a, pt};
		{op_in.carry_out, op_in.operand_sign, op_in.overflow} = 3'($urandom);
		{oc2, oc1} = 2'($urandom);
		op_valid = 1'b1;
		@(posedge clock) #1;
		op_valid = 1'b0;
		wait_ready();
		if (d && s == 4'h4)
			epc = {r[3:0], 8'(ereg[0])};
		else if (d && s == 4'h5)
			epc[7:0] = r;
		else
			epc = epc + 12'h001;
		if (d)
			ereg[s] = r;
		if (a)
			ecf = {op_in.overflow, r == 8'h00, r != 8'h00 && !r[7], op_in.operand_sign,
				op_in.carry_out};
		if (pt)
			exp_par = bad_par;
		chk(pc, epc);
		chk({work, disc1, disc2}, {8'(ereg[0]), 8'(ereg[2]), 8'(ereg[3])});
		chk(ihold, op_in.instr);
		chk(a ? cond : cond[7:5], a ? {oc2, oc1, exp_par, ecf} : {oc2, oc1, exp_par});
		if (!d && s != 4'h1)
			chk(rdata, s inside {4'h4, 4'h5} ? 8'h00 : 8'(ereg[s]));
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	initial
	begin
		void'($urandom(39));
		repeat (12) @(posedge clock);
		#1;
		chk({pc, fstb, op_ready, work, cond}, 32'h0000_0000);
		sys_rst = 1'b0;
		for (int i = 0; i < 32; i++)
			if (i != 1 && i != 17)
				run_op(4'(i), i < 16, 8'($urandom), 1'b0, 1'b0);
		cycle_stretch = 8'h03;
		for (int i = 0; i < 8; i++)
			run_op(4'h6, 1'b0, i < 2 ? 8'h00 : 8'($urandom), 1'b1, 1'b0);
		bad_par = 1'b1;
		run_op(4'h9, 1'b0, 8'h00, 1'b0, 1'b1);
		bad_par = 1'b0;
		run_op(4'h9, 1'b0, 8'h00, 1'b0, 1'b1);
		run_op(4'h4, 1'b1, 8'($urandom), 1'b0, 1'b0);
		run_op(4'h5, 1'b1, 8'($urandom), 1'b0, 1'b0);
		finish_test();
	end
endmodule // mrbc_core_tb
`default_nettype wire
